// [hw/pwm_params.svh]
`ifndef PWM_PARAMS_SVH
`define PWM_PARAMS_SVH

// register byte offsets on the bus (one aligned word each)
`define OFS_PERIOD_TIMER_COUNT 8'h00
`define OFS_PERIOD_COMPARE_VALUE 8'h04
`define OFS_PERIOD_TIMER_CONTROL 8'h08
`define OFS_SECOND_TIMER_COUNT 8'h0C
`define OFS_SECOND_PERIOD_VALUE 8'h10
`define OFS_SECOND_TIMER_CONTROL 8'h14
`define OFS_DUTY_LOW_BYTE 8'h18
`define OFS_DUTY_SHADOW_BYTE 8'h1C
`define OFS_CHANNEL_CONTROL 8'h20
`define OFS_PORT_DIRECTION 8'h24
`define OFS_PIN_STATUS 8'h28

// reset values
`define RST_TIMER_COUNT 8'h00
`define RST_PERIOD_VALUE 8'hFF
`define RST_TIMER_CONTROL 8'h00
`define RST_CHANNEL_CONTROL 8'h00
`define RST_PORT_DIRECTION 8'hFF
`define RST_DUTY 8'h00

// field positions
`define TCON_PRESCALE_LSB 0
`define TCON_ON_BIT 2
`define TCON_POST_LSB 3
`define CCON_MODE_LSB 0
`define CCON_DUTY_LSB 4
`define PORT_PWM_BIT 2

// mode encodings, top two bits of the mode field select pwm
`define MODE_PWM_TOP 2'b11

// prescale ratios 1, 4, 16 as maximum phase counts
`define PRESCALE_MAX_1 4'h0
`define PRESCALE_MAX_4 4'h3
`define PRESCALE_MAX_16 4'hF

`endif

// [hw/pwm_pkg.sv]
package pwm_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [9:0] duty_t;
    typedef enum logic [1:0] {
        RESP_OKAY = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_t;
endpackage

// [hw/period_timer.sv]
`timescale 1ns/10ps
`include "pwm_params.svh"

// 8-bit period timer with 1/4/16 prescaler and 1..16 postscaler
module period_timer
    import pwm_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire byte_t control,
    input wire byte_t period,
    input wire logic count_wr,
    input wire byte_t count_wdata,
    output byte_t count,
    output logic [1:0] sub_count,
    output logic period_end,
    output logic post_event
);
    logic [3:0] phase;
    logic [3:0] phase_max;
    logic [3:0] post;
    logic tick;
    logic timer_on;

    // **************************************************
    // prescaler
    // **************************************************
    // ratio decode: 00 -> 1, 01 -> 4, 1x -> 16
    always_comb begin
        case (control[`TCON_PRESCALE_LSB+1 -: 2]) // see R12
            2'b00: phase_max = `PRESCALE_MAX_1;
            2'b01: phase_max = `PRESCALE_MAX_4;
            default: phase_max = `PRESCALE_MAX_16;
        endcase
    end

    assign timer_on = control[`TCON_ON_BIT];
    assign tick = timer_on && (phase >= phase_max);
    assign period_end = tick && (count == period);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase <= 4'h0;
        end else if (!timer_on || tick) begin
            phase <= 4'h0;
        end else begin
            phase <= phase + 4'h1;
        end
    end

    // low sub-count bits: top two bits of prescaler phase, or zero at 1:1
    always_comb begin
        case (control[`TCON_PRESCALE_LSB+1 -: 2]) // see R9
            2'b00: sub_count = 2'b00;
            2'b01: sub_count = phase[1:0];
            default: sub_count = phase[3:2];
        endcase
    end

    // **************************************************
    // counter
    // **************************************************
    // match clears on the next increment, not immediately
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= `RST_TIMER_COUNT;
        end else if (count_wr) begin
            count <= count_wdata;
        end else if (period_end) begin
            count <= 8'h00; // see R2
        end else if (tick) begin
            count <= count + 8'h01;
        end
    end

    // postscaler only yields a side event, never touches the period; see R11
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            post <= 4'h0;
            post_event <= 1'b0;
        end else begin
            post_event <= 1'b0;
            if (period_end) begin
                if (post >= control[`TCON_POST_LSB +: 4]) begin
                    post <= 4'h0;
                    post_event <= 1'b1;
                end else begin
                    post <= post + 4'h1;
                end
            end
        end
    end
endmodule // period_timer

// [hw/timer_based_pwm_output.sv]
`timescale 1ns/10ps
`include "pwm_params.svh"

// How it works
// R1: period length comes from the software-written period register.
// R2: timer equal to period register clears timer on next increment.
// R3: new period sets output high unless duty value is zero.
// R4: same boundary copies buffered duty into shadow register and two-bit latch.
// R5: duty writes anytime, applied only after next period match.
// R6: duty is low register bits as msbs, control bits 5:4 as lsbs.
// R7: shadow register ignores software writes in pwm mode.
// R8: shadow plus two-bit latch double-buffers duty, no glitches.
// R9: output clears when latched duty equals timer with two sub bits.
// R10: duty above period length leaves output high whole period.
// R11: postscaler never affects pwm frequency, only a side event.
// R12: prescale ratios 1, 4 and 16.
// R13: software sets period, duty, direction, timer, then pwm mode.
// R14: software clears direction bit 2 to make pin an output.
// R15: software sets prescale and timer-on before pwm starts.
// R16: clearing channel control forces output latch low.
// R17: pwm only when mode field holds the pwm encoding.
module timer_based_pwm_output
    import pwm_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic pwm_output_pin,
    output logic pwm_output_pin_oe,
    output logic post_event
);
    // **************************************************
    // registers
    // **************************************************
    byte_t period_compare_value;
    byte_t period_timer_control;
    byte_t second_timer_count;
    byte_t second_period_value;
    byte_t second_timer_control;
    byte_t duty_low_byte;
    byte_t duty_shadow_byte;
    byte_t channel_control;
    byte_t port_direction;
    logic [1:0] duty_latch;
    logic pwm_latch;
    byte_t period_timer_count;
    logic [1:0] sub_count;
    logic period_end;
    logic pwm_mode;

    // the map decodes an 8-bit byte address and packs each register into a 32-bit word
    if (ADDR_W != 8 || DATA_W != 32) begin : g_width_check
        $error("unsupported bus width");
    end

    // bus holding state
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic do_write;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic lane0_wr;

    // byte lane 0 is the only meaningful lane of each register
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr[7:2] == ofs[7:2]);
    endfunction

    function automatic logic mapped(input logic [7:0] addr);
        mapped = (addr[7:2] <= 6'(`OFS_PIN_STATUS >> 2));
    endfunction

    assign pwm_mode = (channel_control[`CCON_MODE_LSB+3 -: 2] == `MODE_PWM_TOP); // see R17

    // **************************************************
    // axi4-lite write channel
    // **************************************************
    // address and data may arrive in either order; each is held until both are in
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    assign wr_data = w_held ? w_data : s_axi_wdata;
    assign wr_strb = w_held ? w_strb : s_axi_wstrb;
    assign do_write = (aw_held || (s_axi_awvalid && s_axi_awready))
                   && (w_held || (s_axi_wvalid && s_axi_wready));
    assign lane0_wr = do_write && wr_strb[0]; // other lanes carry nothing

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    // write response one cycle after both halves are in
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // period register sets the length of each pwm period
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            period_compare_value <= `RST_PERIOD_VALUE;
        end else if (lane0_wr && hit(wr_addr, `OFS_PERIOD_COMPARE_VALUE)) begin
            period_compare_value <= wr_data[7:0]; // see R1
        end
    end

    // timer control; the top bit is unimplemented and stays zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            period_timer_control <= `RST_TIMER_CONTROL;
        end else if (lane0_wr && hit(wr_addr, `OFS_PERIOD_TIMER_CONTROL)) begin
            period_timer_control <= {1'b0, wr_data[6:0]};
        end
    end

    // second timer count is plain storage and drives nothing here
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            second_timer_count <= `RST_TIMER_COUNT;
        end else if (lane0_wr && hit(wr_addr, `OFS_SECOND_TIMER_COUNT)) begin
            second_timer_count <= wr_data[7:0];
        end
    end

    // second period value, storage only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            second_period_value <= `RST_PERIOD_VALUE;
        end else if (lane0_wr && hit(wr_addr, `OFS_SECOND_PERIOD_VALUE)) begin
            second_period_value <= wr_data[7:0];
        end
    end

    // second timer control, storage only; top bit reads zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            second_timer_control <= `RST_TIMER_CONTROL;
        end else if (lane0_wr && hit(wr_addr, `OFS_SECOND_TIMER_CONTROL)) begin
            second_timer_control <= {1'b0, wr_data[6:0]};
        end
    end

    // duty may be rewritten at any time; only the buffer changes, so no glitch
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            duty_low_byte <= `RST_DUTY;
        end else if (lane0_wr && hit(wr_addr, `OFS_DUTY_LOW_BYTE)) begin
            duty_low_byte <= wr_data[7:0]; // see R5
        end
    end

    // channel control; the two top bits are unimplemented
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            channel_control <= `RST_CHANNEL_CONTROL;
        end else if (lane0_wr && hit(wr_addr, `OFS_CHANNEL_CONTROL)) begin
            channel_control <= {2'b00, wr_data[5:0]};
        end
    end

    // port direction; the pin drives only while its bit is low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port_direction <= `RST_PORT_DIRECTION;
        end else if (lane0_wr && hit(wr_addr, `OFS_PORT_DIRECTION)) begin
            port_direction <= wr_data[7:0];
        end
    end

    // **************************************************
    // time base
    // **************************************************
    period_timer u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .control(period_timer_control),
        .period(period_compare_value),
        .count_wr(do_write && wr_strb[0] && hit(wr_addr, `OFS_PERIOD_TIMER_COUNT)),
        .count_wdata(wr_data[7:0]),
        .count(period_timer_count),
        .sub_count(sub_count),
        .period_end(period_end),
        .post_event(post_event)
    );

    // **************************************************
    // duty double buffer
    // **************************************************
    // in pwm mode the shadow is loaded only at the period boundary so a mid-period write cannot glitch
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            duty_shadow_byte <= `RST_DUTY;
            duty_latch <= 2'b00;
        end else if (pwm_mode && period_end) begin
            duty_shadow_byte <= duty_low_byte; // see R4 see R8
            duty_latch <= channel_control[`CCON_DUTY_LSB +: 2]; // see R6
        end else if (!pwm_mode && do_write && wr_strb[0]
                     && hit(wr_addr, `OFS_DUTY_SHADOW_BYTE)) begin
            duty_shadow_byte <= wr_data[7:0]; // writable outside pwm only; see R7
        end
    end

    // **************************************************
    // output latch
    // **************************************************
    // set wins at the boundary; a duty beyond the period never matches; see R10
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pwm_latch <= 1'b0;
        end else if (channel_control == 8'h00 || !pwm_mode) begin
            pwm_latch <= 1'b0; // see R16
        end else if (period_end) begin
            pwm_latch <= ({duty_low_byte, channel_control[`CCON_DUTY_LSB +: 2]} != 10'h000); // see R3
        end else if ({duty_shadow_byte, duty_latch} == {period_timer_count, sub_count}) begin
            pwm_latch <= 1'b0; // see R9
        end
    end

    // software must clear the direction bit for the pin to drive; see R14
    assign pwm_output_pin = pwm_latch;
    assign pwm_output_pin_oe = !port_direction[`PORT_PWM_BIT];

    // **************************************************
    // axi4-lite read channel
    // **************************************************
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr[7:2])
                6'h00: s_axi_rdata <= {24'h000000, period_timer_count};
                6'h01: s_axi_rdata <= {24'h000000, period_compare_value};
                6'h02: s_axi_rdata <= {24'h000000, period_timer_control};
                6'h03: s_axi_rdata <= {24'h000000, second_timer_count};
                6'h04: s_axi_rdata <= {24'h000000, second_period_value};
                6'h05: s_axi_rdata <= {24'h000000, second_timer_control};
                6'h06: s_axi_rdata <= {24'h000000, duty_low_byte};
                6'h07: s_axi_rdata <= {24'h000000, duty_shadow_byte};
                6'h08: s_axi_rdata <= {24'h000000, channel_control};
                6'h09: s_axi_rdata <= {24'h000000, port_direction};
                6'h0A: s_axi_rdata <= {28'h0000000, duty_latch, pwm_mode, pwm_latch};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // timer_based_pwm_output

// [tb/pwm_out_asserts.sv]
`timescale 1ns/10ps
`include "pwm_params.svh"
// **********************
// bus and pin checker
// **********************
module pwm_out_asserts (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pwm_output_pin,
    input wire logic pwm_output_pin_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic wr_go;
    // both write halves taken at one edge, as the bench always offers them
    assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

    a_resp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer not held");
    a_data_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer not held");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (
        wr_go |=> s_axi_bvalid && s_axi_bresp == ($past(s_axi_awaddr) >= 8'h2C ? 2'h2 : 2'h0))
        else $error("write answer wrong");
    a_resp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_mode_off: assert property (
        wr_go && s_axi_awaddr == `OFS_CHANNEL_CONTROL && s_axi_wdata[3:2] != 2'h3
        |-> ##[1:2] !pwm_output_pin) else $error("pin not low outside pwm mode");
    a_oe_dir: assert property (
        wr_go && s_axi_awaddr == `OFS_PORT_DIRECTION |=> pwm_output_pin_oe != $past(s_axi_wdata[2]))
        else $error("pin enable wrong");
endmodule // pwm_out_asserts

// [tb/pwm_load.sv]
`timescale 1ns/10ps
// **********************
// load on the pwm pin
// **********************
module pwm_load (
    input wire logic clk,
    input wire logic pin,
    input wire logic oe,
    output int hi_len,
    output int per_len,
    output int rises
);
    logic last = 1'b0;
    int hi = 0;
    int since = 0;
    // lengths in clock edges; a pin left floating (oe low) never starts a pulse
    always @(posedge clk) begin
        last <= pin;
        since <= since + 1;
        if (pin) hi <= hi + 1;
        if (oe && pin && !last) begin
            per_len <= since;
            since <= 1;
            hi <= 1;
            rises <= rises + 1;
        end
        if (!pin && last) hi_len <= hi;
    end
endmodule // pwm_load

// [tb/timer_based_pwm_output_tb.sv]
`timescale 1ns/10ps
`include "pwm_params.svh"
// **********************
// bench top
// **********************
module timer_based_pwm_output_tb;
    logic clk = 1'b0, reset_n = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pin, oe, post;
    logic [1:0] bresp, rresp;
    int failures = 0, n_checks = 0, hi_len, per_len, rises, n_post = 0;
    // 100 MHz clock
    always #5 clk = ~clk;
    // postscaler events seen by the bench
    always @(posedge clk) if (post) n_post <= n_post + 1;
    timer_based_pwm_output i_timer_based_pwm_output (
        .clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pwm_output_pin(pin), .pwm_output_pin_oe(oe), .post_event(post));
    pwm_load i_pwm_load (.clk(clk), .pin(pin), .oe(oe), .hi_len(hi_len), .per_len(per_len),
        .rises(rises));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        if (failures == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // one write; bready only after the answer shows, so a held answer is seen
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge clk);
            if (awready) ad = 1'b1;
            if (wready) dd = 1'b1;
            if (ad) awvalid <= 1'b0;
            if (dd) wvalid <= 1'b0;
        end
        while (!bvalid) @(posedge clk);
        bready <= 1'b1;
        @(posedge clk);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er = 2'h0);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b1;
        @(posedge clk);
        rready <= 1'b0;
        chk("rdata", {24'h0, ed}, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask
    // wait for n more pulse starts at the load
    task automatic pulses(input int n);
        int r;
        r = rises;
        while (rises < r + n) @(posedge clk);
    endtask
    // software order: period, duty, direction, timer, mode last
    task automatic setup(input logic [7:0] dl, input logic [7:0] cc, input logic [7:0] tc);
        wr(`OFS_PERIOD_COMPARE_VALUE, 8'h09);
        wr(`OFS_DUTY_LOW_BYTE, dl);
        wr(`OFS_PORT_DIRECTION, 8'hFB);
        wr(`OFS_PERIOD_TIMER_CONTROL, tc);
        wr(`OFS_CHANNEL_CONTROL, cc);
    endtask
    // reset values and an unmapped place
    task automatic t_reset();
        rd(`OFS_PERIOD_COMPARE_VALUE, 8'hFF);
        rd(`OFS_PERIOD_TIMER_COUNT, 8'h00);
        rd(`OFS_PERIOD_TIMER_CONTROL, 8'h00);
        rd(`OFS_CHANNEL_CONTROL, 8'h00);
        rd(8'h2C, 8'h00, 2'h2);
        wr(8'h2C, 8'h5A, 2'h2);
        chk("oe", 32'h0, {31'h0, oe});
    endtask
    // pulse shape per prescale ratio, postscaler set to four
    task automatic t_shape();
        int p[3] = '{1, 4, 16};
        int d, n;
        for (int i = 0; i < 3; i++) begin
            d = (i == 0) ? 12 : 14;
            setup(8'h03, {2'h0, d[1:0], 4'hC}, {1'b0, 4'h3, 1'b1, i[1:0]});
            pulses(3);
            chk("period", 10 * p[i], per_len);
            chk("high", d * p[i] / 4 + 1, hi_len);
            // postscale four: one side event in any four whole periods
            n = n_post;
            pulses(4);
            chk("post", n + 1, n_post);
            chk("oe", 32'h1, {31'h0, oe});
            rd(`OFS_DUTY_SHADOW_BYTE, 8'h03);
            wr(`OFS_DUTY_SHADOW_BYTE, 8'h55);
            rd(`OFS_DUTY_SHADOW_BYTE, 8'h03);
            wr(`OFS_CHANNEL_CONTROL, 8'h00);
            repeat (3) @(posedge clk);
            chk("pin", 32'h0, {31'h0, pin});
        end
    endtask
    // steady level held over many cycles
    task automatic t_level(input logic [7:0] dl, input logic [7:0] cc, input logic lvl);
        setup(dl, cc, 8'h04);
        repeat (30) @(posedge clk);
        for (int k = 0; k < 20; k++) begin
            @(posedge clk);
            chk("level", {31'h0, lvl}, {31'h0, pin});
        end
        wr(`OFS_CHANNEL_CONTROL, 8'h00);
    endtask
    // duty rewritten early in a pulse must wait for the boundary
    task automatic t_update();
        setup(8'h03, 8'h0C, 8'h04);
        pulses(2);
        wr(`OFS_DUTY_LOW_BYTE, 8'h06);
        pulses(1);
        chk("high", 32'h4, hi_len);
        pulses(2);
        chk("high", 32'h7, hi_len);
        wr(`OFS_CHANNEL_CONTROL, 8'h00);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_shape();
        t_level(8'h14, 8'h0C, 1'b1);
        t_level(8'h00, 8'h0C, 1'b0);
        t_level(8'h03, 8'h08, 1'b0);
        t_update();
        give_verdict();
    end
    // hang guard: the scenarios need a few thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        give_verdict();
    end
endmodule // timer_based_pwm_output_tb

bind timer_based_pwm_output pwm_out_asserts i_pwm_out_asserts (.clk(clk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pwm_output_pin(pwm_output_pin),
    .pwm_output_pin_oe(pwm_output_pin_oe));
